/* File: src/scs_defs.svh */
// Constants of the serial configuration slave and its host end
`ifndef SCS_DEFS_SVH
`define SCS_DEFS_SVH

// ****************************************
// Link addressing and command layout
// ****************************************
`define SCS_ADDR_W8 8'hd2
`define SCS_CMD_TYPE_BIT 7
`define SCS_BLOCK_CMD 8'h00
`define SCS_IDX_W 7

// ****************************************
// Configuration store
// ****************************************
`define SCS_NUM_BYTES 8
`define SCS_CFG_DEFAULT 64'hffff_ffff_ffff_ff00

// ****************************************
// Timing
// ****************************************
`define SCS_CLK_NS 20
`define SCS_SCL_PERIOD_NS 400
`define SCS_SCL_QTR_CYC ((`SCS_SCL_PERIOD_NS / 4 + `SCS_CLK_NS - 1) / `SCS_CLK_NS)

`endif

/* File: src/scs_pkg.sv */
// Types shared by both ends of the serial configuration link
package scs_pkg;
  typedef logic [7:0] scs_byte_t;
  typedef enum logic [1:0] {OP_BYTE_WR, OP_BYTE_RD, OP_BLK_WR, OP_BLK_RD} scs_op_t;
  typedef enum logic [2:0] {D_IDLE, D_RX, D_ACK, D_TX, D_TXACK} scs_dstate_t;
  typedef enum logic [1:0] {P_ADDR, P_CMD, P_CNT, P_DATA} scs_phase_t;
  typedef enum logic [3:0] {
    H_IDLE, H_START, H_ADDRW, H_CMD, H_CNT, H_WDATA, H_RSTART, H_ADDRR, H_RCNT, H_RDATA, H_STOP
  } scs_hstate_t;
endpackage : scs_pkg

/* File: src/scs_if.sv */
// Two-wire link between the host end and the configuration slave
`timescale 1ns/100ps
interface scs_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic sda;

  // Open-drain data line with pull-up: any enabled driver at 0 wins
  assign sda = (~host_sda_oe | host_sda_o) & (~dev_sda_oe | dev_sda_o);

  modport host (output scl, output host_sda_o, output host_sda_oe, input sda);
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
endinterface : scs_if

/* File: src/scs_slave.sv */
// Configuration slave: serial protocol engine and configuration byte store
`timescale 1ns/100ps
`include "scs_defs.svh"
module scs_slave (
  input wire logic clk,
  input wire logic rst_n,
  scs_if.dev bus,
  output logic [8*`SCS_NUM_BYTES-1:0] cfg_o
);
  import scs_pkg::*;

  // ****************************************
  // Pin synchronisers and line events
  // ****************************************
  logic scl_s1_r, scl_s2_r, scl_s3_r;
  logic sda_s1_r, sda_s2_r, sda_s3_r;
  logic scl_rise, scl_fall, start_seen, stop_seen;

  // Two flops per pin, a third only for edge finding
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_s3_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_s3_r <= 1'b1;
    end else begin
      scl_s1_r <= bus.scl;
      scl_s2_r <= scl_s1_r;
      scl_s3_r <= scl_s2_r;
      sda_s1_r <= bus.sda;
      sda_s2_r <= sda_s1_r;
      sda_s3_r <= sda_s2_r;
    end
  end

  // Data moving while the clock is high marks start or stop
  assign scl_rise = scl_s2_r & ~scl_s3_r;
  assign scl_fall = ~scl_s2_r & scl_s3_r;
  assign start_seen = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
  assign stop_seen = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;

  // ****************************************
  // Protocol state
  // ****************************************
  scs_dstate_t state_r, state_nxt;
  scs_phase_t phase_r, phase_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  scs_byte_t sh_r, sh_nxt;
  scs_byte_t tx_r, tx_nxt;
  logic rd_r, rd_nxt;
  logic blk_r, blk_nxt;
  logic first_r, first_nxt;
  logic [`SCS_IDX_W-1:0] ptr_r, ptr_nxt;
  logic oe_r, oe_nxt;
  scs_byte_t cfg_r [`SCS_NUM_BYTES];
  scs_byte_t cfg_nxt [`SCS_NUM_BYTES];
  scs_byte_t rx_byte;

  // Unimplemented indices read back as zero
  function automatic scs_byte_t rd_byte(input logic [`SCS_IDX_W-1:0] idx);
    scs_byte_t val;
    val = 8'h00;
    if (idx < (`SCS_IDX_W)'(`SCS_NUM_BYTES)) begin
      val = cfg_r[idx[$clog2(`SCS_NUM_BYTES)-1:0]];
    end
    return val;
  endfunction : rd_byte

  // Next-state computation for the whole engine
  always_comb begin
    state_nxt = state_r;
    phase_nxt = phase_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    tx_nxt = tx_r;
    rd_nxt = rd_r;
    blk_nxt = blk_r;
    first_nxt = first_r;
    ptr_nxt = ptr_r;
    oe_nxt = oe_r;
    cfg_nxt = cfg_r;
    rx_byte = {sh_r[6:0], sda_s2_r};
    if (stop_seen) begin
      // Bytes already stored stay; a partial byte is dropped
      state_nxt = D_IDLE;
      oe_nxt = 1'b0;
    end else if (start_seen) begin
      // Repeated start keeps command context for the read half
      state_nxt = D_RX;
      phase_nxt = P_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else begin
      unique case (state_r)
        D_IDLE: begin
        end
        D_RX: begin
          if (scl_rise && cnt_r != 4'h8) begin
            sh_nxt = rx_byte;
            cnt_nxt = cnt_r + 4'h1;
            if (cnt_r == 4'h7) begin
              unique case (phase_r)
                P_ADDR: begin
                  if (rx_byte[7:1] != 7'(`SCS_ADDR_W8 >> 1)) begin
                    state_nxt = D_IDLE;
                  end else begin
                    rd_nxt = rx_byte[0];
                    phase_nxt = rx_byte[0] ? P_DATA : P_CMD;
                    // Block read answers with the byte count first
                    tx_nxt = (blk_r && first_r) ? 8'(`SCS_NUM_BYTES) : rd_byte(ptr_r);
                  end
                end
                P_CMD: begin
                  blk_nxt = ~rx_byte[`SCS_CMD_TYPE_BIT];
                  first_nxt = ~rx_byte[`SCS_CMD_TYPE_BIT];
                  // Block always begins at byte 0 whatever the low bits hold
                  ptr_nxt = rx_byte[`SCS_CMD_TYPE_BIT] ? rx_byte[`SCS_IDX_W-1:0] : '0;
                  phase_nxt = rx_byte[`SCS_CMD_TYPE_BIT] ? P_DATA : P_CNT;
                end
                P_CNT: begin
                  // Count is acknowledged but not used to limit writes
                  phase_nxt = P_DATA;
                end
                P_DATA: begin
                  if (ptr_r < (`SCS_IDX_W)'(`SCS_NUM_BYTES)) begin
                    cfg_nxt[ptr_r[$clog2(`SCS_NUM_BYTES)-1:0]] = rx_byte;
                  end
                  if (blk_r) begin
                    ptr_nxt = ptr_r + 1'b1;
                  end
                end
              endcase
            end
          end else if (scl_fall && cnt_r == 4'h8) begin
            oe_nxt = 1'b1;
            state_nxt = D_ACK;
          end
        end
        D_ACK: begin
          if (scl_fall) begin
            if (rd_r) begin
              // First read bit goes out on the same falling edge
              oe_nxt = ~tx_r[7];
              tx_nxt = {tx_r[6:0], 1'b0};
              cnt_nxt = 4'h1;
              state_nxt = D_TX;
            end else begin
              oe_nxt = 1'b0;
              cnt_nxt = 4'h0;
              state_nxt = D_RX;
            end
          end
        end
        D_TX: begin
          if (scl_fall) begin
            if (cnt_r == 4'h8) begin
              oe_nxt = 1'b0;
              state_nxt = D_TXACK;
            end else begin
              oe_nxt = ~tx_r[7];
              tx_nxt = {tx_r[6:0], 1'b0};
              cnt_nxt = cnt_r + 4'h1;
            end
          end
        end
        D_TXACK: begin
          if (scl_rise) begin
            if (!sda_s2_r) begin
              cnt_nxt = 4'h0;
              state_nxt = D_TX;
              if (first_r) begin
                first_nxt = 1'b0;
                tx_nxt = rd_byte(ptr_r);
              end else if (blk_r) begin
                ptr_nxt = ptr_r + 1'b1;
                tx_nxt = rd_byte(ptr_r + 1'b1);
              end else begin
                tx_nxt = rd_byte(ptr_r);
              end
            end else begin
              // Not-acknowledge ends the read; wait for stop
              state_nxt = D_IDLE;
            end
          end
        end
        // Unused state codes fall back to waiting for a start
        default: state_nxt = D_IDLE;
      endcase
    end
  end

  // Registers of the engine and the store
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_r <= D_IDLE;
      phase_r <= P_ADDR;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      rd_r <= 1'b0;
      blk_r <= 1'b0;
      first_r <= 1'b0;
      ptr_r <= '0;
      oe_r <= 1'b0;
      for (int i = 0; i < `SCS_NUM_BYTES; i++) begin
        cfg_r[i] <= 8'(`SCS_CFG_DEFAULT >> (8 * i));
      end
    end else begin
      state_r <= state_nxt;
      phase_r <= phase_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      tx_r <= tx_nxt;
      rd_r <= rd_nxt;
      blk_r <= blk_nxt;
      first_r <= first_nxt;
      ptr_r <= ptr_nxt;
      oe_r <= oe_nxt;
      cfg_r <= cfg_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Only ever pulls low; the pull-up gives the high level
  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = oe_r;

  // Each stored bit steers one output buffer enable
  for (genvar g = 0; g < `SCS_NUM_BYTES; g++) begin : g_flat
    assign cfg_o[8*g +: 8] = cfg_r[g];
  end
endmodule : scs_slave

/* File: src/scs_host.sv */
// Host end: drives the serial clock and sequences byte and block transfers
`timescale 1ns/100ps
`include "scs_defs.svh"
module scs_host (
  input wire logic clk,
  input wire logic rst_n,
  scs_if.host bus,
  input wire logic go_i,
  input wire scs_pkg::scs_op_t op_i,
  input wire logic [`SCS_IDX_W-1:0] idx_i,
  input wire logic [7:0] len_i,
  input wire logic [7:0] wdata_i,
  output logic wr_take_o,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  output logic busy_o,
  output logic done_o,
  output logic nack_o
);
  import scs_pkg::*;

  // ****************************************
  // Data line synchroniser
  // ****************************************
  logic sda_s1_r, sda_s2_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
    end else begin
      sda_s1_r <= bus.sda;
      sda_s2_r <= sda_s1_r;
    end
  end

  // ****************************************
  // Sequencer and bit engine
  // ****************************************
  scs_hstate_t st_r, st_nxt;
  logic [2:0] qdiv_r, qdiv_nxt;
  logic [1:0] qt_r, qt_nxt;
  logic [3:0] bit_r, bit_nxt;
  scs_byte_t sh_r, sh_nxt;
  logic scl_r, scl_nxt;
  logic oe_r, oe_nxt;
  scs_op_t op_r, op_nxt;
  scs_byte_t cmd_r, cmd_nxt;
  logic [7:0] len_r, len_nxt;
  logic [7:0] rem_r, rem_nxt;
  logic ackd_r, ackd_nxt;
  logic take_nxt, rdv_nxt, busy_nxt, done_nxt, nack_nxt;
  scs_byte_t rdd_nxt;
  logic tick, is_tx, ack_out, is_blk;
  scs_hstate_t ns;

  assign tick = qdiv_r == 3'(`SCS_SCL_QTR_CYC - 1);
  assign is_tx = st_r inside {H_ADDRW, H_CMD, H_CNT, H_WDATA, H_ADDRR};
  assign is_blk = op_r inside {OP_BLK_WR, OP_BLK_RD};
  // Ack every byte still wanted, refuse the last one
  assign ack_out = (st_r == H_RCNT) ? (rem_r != 8'h00) : (rem_r > 8'h01);

  always_comb begin
    st_nxt = st_r;
    qdiv_nxt = (st_r == H_IDLE || tick) ? 3'h0 : qdiv_r + 3'h1;
    qt_nxt = qt_r;
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    scl_nxt = scl_r;
    oe_nxt = oe_r;
    op_nxt = op_r;
    cmd_nxt = cmd_r;
    len_nxt = len_r;
    rem_nxt = rem_r;
    ackd_nxt = ackd_r;
    take_nxt = 1'b0;
    rdv_nxt = 1'b0;
    rdd_nxt = rd_data_o;
    busy_nxt = busy_o;
    done_nxt = 1'b0;
    nack_nxt = nack_o;
    ns = st_r;
    if (st_r == H_IDLE) begin
      scl_nxt = 1'b1;
      oe_nxt = 1'b0;
      if (go_i) begin
        op_nxt = op_i;
        // Byte ops carry the index, block ops send all zero
        cmd_nxt = op_i inside {OP_BYTE_WR, OP_BYTE_RD} ? {1'b1, idx_i} : `SCS_BLOCK_CMD;
        len_nxt = len_i;
        rem_nxt = op_i inside {OP_BYTE_WR, OP_BYTE_RD} ? 8'h01 : len_i;
        nack_nxt = 1'b0;
        busy_nxt = 1'b1;
        qt_nxt = 2'h0;
        st_nxt = H_START;
      end
    end else if (tick) begin
      qt_nxt = qt_r + 2'h1;
      if (st_r == H_START || st_r == H_RSTART) begin
        // Release, raise clock, pull data low, drop clock
        unique case (qt_r)
          2'h0: oe_nxt = 1'b0;
          2'h1: scl_nxt = 1'b1;
          2'h2: oe_nxt = 1'b1;
          2'h3: begin
            scl_nxt = 1'b0;
            ns = (st_r == H_START) ? H_ADDRW : H_ADDRR;
          end
        endcase
      end else if (st_r == H_STOP) begin
        unique case (qt_r)
          2'h0: oe_nxt = 1'b1;
          2'h1: scl_nxt = 1'b1;
          2'h2: oe_nxt = 1'b0;
          2'h3: begin
            st_nxt = H_IDLE;
            busy_nxt = 1'b0;
            done_nxt = 1'b1;
          end
        endcase
      end else begin
        unique case (qt_r)
          2'h0: oe_nxt = (bit_r != 4'h8) ? (is_tx & ~sh_r[7]) : (~is_tx & ack_out);
          2'h1: scl_nxt = 1'b1;
          2'h2: begin
            if (bit_r != 4'h8) begin
              sh_nxt = {sh_r[6:0], sda_s2_r};
            end else begin
              ackd_nxt = ~sda_s2_r;
            end
          end
          2'h3: begin
            scl_nxt = 1'b0;
            if (bit_r != 4'h8) begin
              bit_nxt = bit_r + 4'h1;
            end else begin
              bit_nxt = 4'h0;
              if (is_tx && !ackd_r) begin
                nack_nxt = 1'b1;
                ns = H_STOP;
              end else begin
                unique case (st_r)
                  H_ADDRW: ns = H_CMD;
                  H_CMD: ns = (op_r == OP_BLK_WR) ? H_CNT : (op_r == OP_BYTE_WR) ? H_WDATA : H_RSTART;
                  H_CNT: ns = (rem_r == 8'h00) ? H_STOP : H_WDATA;
                  H_WDATA: begin
                    rem_nxt = rem_r - 8'h01;
                    ns = (rem_r == 8'h01) ? H_STOP : H_WDATA;
                  end
                  H_ADDRR: ns = is_blk ? H_RCNT : H_RDATA;
                  H_RCNT: ns = (rem_r == 8'h00) ? H_STOP : H_RDATA;
                  H_RDATA: begin
                    rdv_nxt = 1'b1;
                    rdd_nxt = sh_r;
                    rem_nxt = rem_r - 8'h01;
                    ns = (rem_r == 8'h01) ? H_STOP : H_RDATA;
                  end
                  default: ns = H_STOP;
                endcase
              end
            end
          end
        endcase
      end
      if (ns != st_r) begin
        st_nxt = ns;
      end
      // Load the next outgoing byte as its first bit slot begins
      if (qt_r == 2'h3 && (ns != st_r || ns == H_WDATA) && !(st_r == H_WDATA && bit_r != 4'h8)) begin
        unique case (ns)
          H_ADDRW: sh_nxt = `SCS_ADDR_W8;
          H_CMD: sh_nxt = cmd_r;
          H_CNT: sh_nxt = len_r;
          H_WDATA: begin
            sh_nxt = wdata_i;
            take_nxt = 1'b1;
          end
          H_ADDRR: sh_nxt = `SCS_ADDR_W8 | 8'h01;
          default: sh_nxt = sh_r;
        endcase
      end
    end
  end

  // Registers of the host end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_r <= H_IDLE;
      qdiv_r <= 3'h0;
      qt_r <= 2'h0;
      bit_r <= 4'h0;
      sh_r <= 8'h00;
      scl_r <= 1'b1;
      oe_r <= 1'b0;
      op_r <= OP_BYTE_WR;
      cmd_r <= 8'h00;
      len_r <= 8'h00;
      rem_r <= 8'h00;
      ackd_r <= 1'b0;
      wr_take_o <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_data_o <= 8'h00;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      nack_o <= 1'b0;
    end else begin
      st_r <= st_nxt;
      qdiv_r <= qdiv_nxt;
      qt_r <= qt_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      scl_r <= scl_nxt;
      oe_r <= oe_nxt;
      op_r <= op_nxt;
      cmd_r <= cmd_nxt;
      len_r <= len_nxt;
      rem_r <= rem_nxt;
      ackd_r <= ackd_nxt;
      wr_take_o <= take_nxt;
      rd_valid_o <= rdv_nxt;
      rd_data_o <= rdd_nxt;
      busy_o <= busy_nxt;
      done_o <= done_nxt;
      nack_o <= nack_nxt;
    end
  end

  assign bus.scl = scl_r;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = oe_r;
endmodule : scs_host

/* File: testbench/scs_link_sva.sv */
// Checker of the two-wire link between the host end and the configuration slave
`timescale 1ns/100ps
module scs_link_sva (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  // ****************
  // Link drive and timing
  // ****************
  // One domain only, so clock and reset are named once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  chk_dev_open_drain: assert property (dev_sda_oe |-> !dev_sda_o)
    else $error("device drives the data line high");
  chk_host_open_drain: assert property (host_sda_oe |-> !host_sda_o)
    else $error("host drives the data line high");
  // Device may only move the data line while the clock is low
  chk_dev_edge_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device changed data while clock high");
  chk_dev_hold: assert property ($rose(dev_sda_oe) |-> dev_sda_oe [*8])
    else $error("device low drive too short");
  // A start keeps the clock high for a while before the first bit
  chk_start_form: assert property (($fell(sda) && scl) |-> scl [*3])
    else $error("start not followed by high clock");
  chk_stop_idle: assert property (($rose(sda) && scl) |-> scl [*8])
    else $error("clock left idle level after stop");
  chk_scl_high_span: assert property ($rose(scl) |-> scl [*8])
    else $error("clock high phase too short");
  chk_scl_low_span: assert property ($fell(scl) |-> !scl [*8])
    else $error("clock low phase too short");
  // Low phase ends within a fixed slot: a stuck clock shows here
  chk_bit_slot: assert property ($fell(scl) |-> ##[9:11] $rose(scl))
    else $error("clock low phase not ended in time");
endmodule : scs_link_sva

/* File: testbench/scs_slave_tb.sv */
// Self-checking bench joining the host end and the configuration slave
`timescale 1ns/100ps
`include "scs_defs.svh"
module scs_slave_tb;
  import scs_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic go_i = 1'b0;
  scs_op_t op_i = OP_BYTE_WR;
  logic [6:0] idx_i = 7'h00;
  logic [7:0] len_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_take_o, rd_valid_o, busy_o, done_o, nack_o;
  logic [7:0] rd_data_o;
  logic [63:0] cfg_o;
  logic [63:0] exp_cfg = `SCS_CFG_DEFAULT;
  logic [7:0] blk [3] = '{8'h11, 8'h22, 8'h33};
  scs_byte_t wq[$];
  scs_byte_t rq[$];
  logic [7:0] sh = 8'h00;
  logic [7:0] first_byte = 8'h00;
  int nb = 0;
  int bad_count = 0;
  int checks = 0;

  // ****************
  // Clock, ends, checker
  // ****************
  always #10 clk = ~clk;
  scs_if bus ();
  scs_host scs_host_i (.clk(clk), .rst_n(rst_n), .bus(bus.host), .go_i(go_i), .op_i(op_i), .idx_i(idx_i),
    .len_i(len_i), .wdata_i(wdata_i), .wr_take_o(wr_take_o), .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o),
    .busy_o(busy_o), .done_o(done_o), .nack_o(nack_o));
  scs_slave scs_slave_i (.clk(clk), .rst_n(rst_n), .bus(bus.dev), .cfg_o(cfg_o));
  scs_link_sva scs_link_sva_i (.clk(clk), .rst_n(rst_n), .scl(bus.scl), .host_sda_o(bus.host_sda_o),
    .host_sda_oe(bus.host_sda_oe), .dev_sda_o(bus.dev_sda_o), .dev_sda_oe(bus.dev_sda_oe), .sda(bus.sda));

  // First byte after each start, rebuilt from the wires, not the host
  always @(negedge bus.sda) if (bus.scl === 1'b1) nb = 0;
  always @(posedge bus.scl) begin
    sh = {sh[6:0], bus.sda};
    nb = nb + 1;
    if (nb == 8) first_byte = sh;
  end
  // Next write byte goes up at the falling edge after each take pulse
  always @(negedge clk) begin
    if (wr_take_o === 1'b1 && wq.size() > 0) void'(wq.pop_front());
    wdata_i = (wq.size() > 0) ? wq[0] : 8'h00;
    if (rd_valid_o === 1'b1) rq.push_back(rd_data_o);
  end

  // ****************
  // Tasks
  // ****************
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One transaction; bounded wait for the done pulse
  task automatic run(input scs_op_t op, input logic [6:0] idx, input logic [7:0] len);
    int n;
    n = 0;
    @(negedge clk);
    go_i = 1'b1;
    op_i = op;
    idx_i = idx;
    len_i = len;
    @(negedge clk);
    go_i = 1'b0;
    chk("busy", 1, busy_o);
    while (done_o !== 1'b1 && n < 5000) begin
      @(negedge clk);
      n++;
    end
    chk("done", 1, done_o);
    chk("busy end", 0, busy_o);
  endtask : run

  task automatic wr_byte(input logic [6:0] idx, input logic [7:0] d);
    wq.push_back(d);
    if (idx < 7'd8) exp_cfg[8*idx +: 8] = d;
    run(OP_BYTE_WR, idx, 8'h00);
    chk("nack", 0, nack_o);
    chk("bytes taken", 0, wq.size());
    chk("write address", 8'hd2, first_byte);
    chk("config", exp_cfg, cfg_o);
  endtask : wr_byte

  task automatic rd_byte(input logic [6:0] idx, input logic [7:0] exp);
    rq.delete();
    run(OP_BYTE_RD, idx, 8'h00);
    chk("read count", 1, rq.size());
    chk("read byte", exp, (rq.size() > 0) ? rq[0] : 8'hxx);
    chk("read address", 8'hd3, first_byte);
  endtask : rd_byte

  // Block read of n bytes compared against the expected store from byte 0
  task automatic rd_blk(input int n);
    rq.delete();
    run(OP_BLK_RD, 7'h00, n[7:0]);
    chk("block count", n, rq.size());
    for (int i = 0; i < n && i < rq.size(); i++) chk("block byte", exp_cfg[8*i +: 8], rq[i]);
  endtask : rd_blk

  task automatic test_done();
    $display("TB: %0d mismatches in %0d checks", bad_count, checks);
    if (bad_count == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  // ****************
  // Tests
  // ****************
  // Longest transfer is about 2220 cycles, the whole test under 9000; over four times margin
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    $display("CHECK FAILED watchdog expected done seen timeout");
    test_done();
  end

  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    chk("config after reset", `SCS_CFG_DEFAULT, cfg_o);
    chk("idle lines", 2'b11, {bus.scl, bus.sda});
    wr_byte(7'd3, 8'ha5);
    wr_byte(7'd7, 8'h3c);
    rd_byte(7'd3, 8'ha5);
    rd_byte(7'd0, 8'h00);
    wr_byte(7'd9, 8'h77);
    rd_byte(7'd127, 8'h00);
    // Block write stops after three bytes; the rest must stay as they were
    foreach (blk[i]) begin
      wq.push_back(blk[i]);
      exp_cfg[8*i +: 8] = blk[i];
    end
    run(OP_BLK_WR, 7'h00, 8'd3);
    chk("block nack", 0, nack_o);
    chk("block bytes taken", 0, wq.size());
    chk("config", exp_cfg, cfg_o);
    rd_blk(8);
    rd_blk(2);
    test_done();
  end
endmodule : scs_slave_tb
